// ---- design/perf_event_counter.sv ----
// Behaviour
// R1 - Code 4BH umask 01H counts executed all-levels-hint prefetches missing every cache.
// R2 - Code 4BH umask 02H counts executed second-level-hint prefetches missing every cache.
// R3 - Prefetch misses count at execution, squashed speculative ones included.
// R4 - Code 4CH umask 00H counts loads hitting an unfinished software prefetch line.
// R5 - Code 4EH umask 10H counts every data cache prefetch request, rejected too.
// R6 - Data cache prefetch requests are rejected while second-level cache is busy.
// R7 - Code 60H adds pending full-line bus reads to the counter every cycle.
// R8 - Only full-line cacheable data reads are pending; ownership reads, fetches excluded.
// R9 - Code 61H counts each bus-not-ready assertion this device drives.
// R10 - Each bus-not-ready assertion lasts exactly two bus cycles.
// R11 - Bus-not-ready asserts when outstanding transactions approach the bus limit.
// R12 - No transaction is issued while bus-not-ready is asserted.
// R13 - Code 62H counts bus cycles with the data-valid strobe asserted.
// R14 - Own-agent qualifier counts only cycles this device drives data.
// R15 - Any-agent qualifier counts every data-valid cycle from any agent.
// R16 - The counter advances only when code and umask both match an event.
`timescale 1ns/1ps
`default_nettype none
module perf_event_counter
  import perf_event_pkg::*;
#(
  parameter int CNT_W = 32,
  parameter int PEND_W = 4,
  parameter int LEVEL_W = 4,
  parameter int STALL_LEVEL = 6
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic prefetch_miss_in,
  input wire logic [1:0] prefetch_hint_in,
  input wire logic load_hit_prefetch_in,
  input wire logic dc_prefetch_req_in,
  input wire logic l2_busy_in,
  output logic dc_prefetch_accept_out,
  input wire logic issue_req_in,
  input wire logic issue_full_line_in,
  input wire logic line_done_in,
  output logic issue_grant_out,
  input wire logic [LEVEL_W-1:0] outstanding_level_in,
  input wire logic bus_not_ready_in,
  output logic bus_not_ready_out,
  input wire logic data_valid_strobe_in,
  input wire logic own_data_drive_in
);

  // ==========================================================
  // Elaboration checks
  if (PEND_W < 1 || CNT_W < PEND_W + 1 || CNT_W > 32) begin : g_bad_width
    $error("perf_event_counter: unsupported widths");
  end
  if (STALL_LEVEL < 1 || STALL_LEVEL >= (1 << LEVEL_W)) begin : g_bad_level
    $error("perf_event_counter: stall level out of range");
  end

  localparam logic [LEVEL_W-1:0] STALL_LVL = LEVEL_W'(STALL_LEVEL);
  localparam logic [PEND_W-1:0] PEND_MAX = {PEND_W{1'b1}};

  typedef struct packed {
    logic [7:0] code;
    logic [7:0] umask;
    logic enable;
    logic [CNT_W-1:0] counter;
    logic [PEND_W-1:0] pending;
    logic [1:0] stall_cnt;
    logic [31:0] rdata;
  } state_t;

  state_t s_r;
  state_t s_nxt;
  logic [PEND_W-1:0] inc;
  logic stall_start;
  logic read_add;
  logic read_sub;
  logic agent_ok;

  // ==========================================================
  // Handshakes
  assign bus_not_ready_out = (s_r.stall_cnt != 2'h0);
  assign issue_grant_out = issue_req_in && !bus_not_ready_out && !bus_not_ready_in; // [R12]
  assign dc_prefetch_accept_out = dc_prefetch_req_in && !l2_busy_in; // [R6]
  assign rdata_out = s_r.rdata;

  // ==========================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    inc = '0;
    agent_ok = (s_r.umask == UM_AGENT_THIS) || (s_r.umask == UM_AGENT_ALL);
    stall_start = (s_r.stall_cnt == 2'h0) && (outstanding_level_in >= STALL_LVL); // [R11]
    read_add = issue_grant_out && issue_full_line_in && (s_r.pending != PEND_MAX); // [R8]
    read_sub = line_done_in && (s_r.pending != '0);
    // Stall signal timing
    if (stall_start) begin
      s_nxt.stall_cnt = STALL_CYCLES; // [R10]
    end else if (s_r.stall_cnt != 2'h0) begin
      s_nxt.stall_cnt = s_r.stall_cnt - 2'h1;
    end
    // Pending reads from issue until last chunk
    if (read_add && !read_sub) begin
      s_nxt.pending = s_r.pending + PEND_W'(1); // [R7]
    end else if (!read_add && read_sub) begin
      s_nxt.pending = s_r.pending - PEND_W'(1);
    end
    // Event selection
    case (s_r.code) // [R16]
      EV_PF_MISS: begin
        if (s_r.umask == UM_PF_T0 && prefetch_miss_in &&
            prefetch_hint_in == HINT_ALL_LEVELS) begin
          inc = PEND_W'(1); // [R1] [R3]
        end else if (s_r.umask == UM_PF_T1T2 && prefetch_miss_in &&
            (prefetch_hint_in == HINT_SECOND_A || prefetch_hint_in == HINT_SECOND_B)) begin
          inc = PEND_W'(1); // [R2] [R3]
        end
      end
      EV_LOAD_HIT_PF: begin
        if (s_r.umask == UM_LOAD_HIT_PF && load_hit_prefetch_in) begin
          inc = PEND_W'(1); // [R4]
        end
      end
      EV_DC_PF_REQ: begin
        if (s_r.umask == UM_DC_PF_REQ && dc_prefetch_req_in) begin
          inc = PEND_W'(1); // [R5]
        end
      end
      EV_READ_PENDING: begin
        if (agent_ok) begin
          inc = s_r.pending; // [R7]
        end
      end
      EV_STALL: begin
        if (agent_ok && stall_start) begin
          inc = PEND_W'(1); // [R9]
        end
      end
      EV_DATA_VALID: begin
        if (s_r.umask == UM_AGENT_THIS && data_valid_strobe_in && own_data_drive_in) begin
          inc = PEND_W'(1); // [R13] [R14]
        end else if (s_r.umask == UM_AGENT_ALL && data_valid_strobe_in) begin
          inc = PEND_W'(1); // [R13] [R15]
        end
      end
      default: begin
        inc = '0;
      end
    endcase
    if (s_r.enable) begin
      s_nxt.counter = s_r.counter + CNT_W'(inc);
    end
    // Register writes
    if (wr_in) begin
      case (addr_in)
        ADDR_CTRL: begin
          s_nxt.code = wdata_in[CTRL_CODE_LSB +: 8];
          s_nxt.umask = wdata_in[CTRL_UMASK_LSB +: 8];
          s_nxt.enable = wdata_in[CTRL_EN_BIT];
        end
        ADDR_COUNT: begin
          s_nxt.counter = wdata_in[CNT_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // Register reads, data stand one cycle
    s_nxt.rdata = '0;
    if (rd_in) begin
      case (addr_in)
        ADDR_CTRL: begin
          s_nxt.rdata[CTRL_CODE_LSB +: 8] = s_r.code;
          s_nxt.rdata[CTRL_UMASK_LSB +: 8] = s_r.umask;
          s_nxt.rdata[CTRL_EN_BIT] = s_r.enable;
        end
        ADDR_COUNT: begin
          s_nxt.rdata[CNT_W-1:0] = s_r.counter;
        end
        ADDR_STATUS: begin
          s_nxt.rdata[PEND_W-1:0] = s_r.pending;
          s_nxt.rdata[STAT_STALL_BIT] = bus_not_ready_out;
        end
        default: begin
          s_nxt.rdata = '0;
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      s_r.code <= RST_CODE;
      s_r.umask <= RST_UMASK;
      s_r.enable <= RST_EN;
      s_r.counter <= '0;
      s_r.pending <= '0;
      s_r.stall_cnt <= 2'h0;
      s_r.rdata <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  logic quiet;
  assign quiet = s_r.enable && !wr_in;

  a_stall_two_cycles: assert property ( // [R10]
    $rose(bus_not_ready_out) |-> ##1 bus_not_ready_out ##1 !bus_not_ready_out)
    else $error("stall signal not exactly two cycles");
  a_stall_trigger: assert property ( // [R11]
    (!bus_not_ready_out && outstanding_level_in >= STALL_LVL) |=> bus_not_ready_out)
    else $error("stall signal missed a high level");
  a_no_issue_stall: assert property ( // [R12]
    bus_not_ready_out |-> !issue_grant_out)
    else $error("issue granted during stall");
  a_stall_counted: assert property ( // [R9]
    (quiet && s_r.code == EV_STALL &&
     (s_r.umask == UM_AGENT_THIS || s_r.umask == UM_AGENT_ALL) &&
     !bus_not_ready_out && outstanding_level_in >= STALL_LVL)
    |=> s_r.counter == $past(s_r.counter) + 1)
    else $error("stall assertion not counted");
  a_stall_once_only: assert property ( // [R9]
    (quiet && s_r.code == EV_STALL && s_r.umask == UM_AGENT_THIS && bus_not_ready_out)
    |=> s_r.counter == $past(s_r.counter))
    else $error("stall counted more than once");
  a_stall_no_early: assert property ( // [R11]
    (!bus_not_ready_out && outstanding_level_in < STALL_LVL) |=> !bus_not_ready_out)
    else $error("stall signal raised below the level");
  a_grant_when_free: assert property ( // [R12]
    (issue_req_in && !bus_not_ready_out && !bus_not_ready_in) |-> issue_grant_out)
    else $error("issue refused on a free bus");
  a_t0_miss_count: assert property ( // [R1]
    (quiet && s_r.code == EV_PF_MISS && s_r.umask == UM_PF_T0 && prefetch_miss_in &&
     prefetch_hint_in == HINT_ALL_LEVELS) |=> s_r.counter == $past(s_r.counter) + 1)
    else $error("all-levels prefetch miss not counted");
  a_t1t2_no_t0: assert property ( // [R2]
    (quiet && s_r.code == EV_PF_MISS && s_r.umask == UM_PF_T1T2 &&
     prefetch_hint_in == HINT_ALL_LEVELS) |=> s_r.counter == $past(s_r.counter))
    else $error("second-level event counted an all-levels hint");
  a_pending_sum: assert property ( // [R7]
    (quiet && s_r.code == EV_READ_PENDING && s_r.umask == UM_AGENT_THIS)
    |=> s_r.counter == $past(s_r.counter) + CNT_W'($past(s_r.pending)))
    else $error("pending reads not added");
  a_partial_excluded: assert property ( // [R8]
    (issue_grant_out && !issue_full_line_in && !line_done_in)
    |=> s_r.pending == $past(s_r.pending))
    else $error("non full-line read became pending");
  a_own_data_only: assert property ( // [R14]
    (quiet && s_r.code == EV_DATA_VALID && s_r.umask == UM_AGENT_THIS &&
     !own_data_drive_in) |=> s_r.counter == $past(s_r.counter))
    else $error("foreign data cycle counted as own");
  a_any_data: assert property ( // [R15]
    (quiet && s_r.code == EV_DATA_VALID && s_r.umask == UM_AGENT_ALL &&
     data_valid_strobe_in) |=> s_r.counter == $past(s_r.counter) + 1)
    else $error("data-valid cycle not counted");
  a_mismatch_idle: assert property ( // [R16]
    (quiet && s_r.code == EV_DC_PF_REQ && s_r.umask != UM_DC_PF_REQ)
    |=> s_r.counter == $past(s_r.counter))
    else $error("counter moved on umask mismatch");
  a_reject_counted: assert property ( // [R5]
    (quiet && s_r.code == EV_DC_PF_REQ && s_r.umask == UM_DC_PF_REQ &&
     dc_prefetch_req_in && l2_busy_in) |=> s_r.counter == $past(s_r.counter) + 1)
    else $error("rejected prefetch request not counted");
  a_dc_accept_count: assert property ( // [R5]
    (quiet && s_r.code == EV_DC_PF_REQ && s_r.umask == UM_DC_PF_REQ &&
     dc_prefetch_req_in && !l2_busy_in) |=> s_r.counter == $past(s_r.counter) + 1)
    else $error("accepted prefetch request not counted");
  a_busy_no_accept: assert property ( // [R6]
    (dc_prefetch_req_in && l2_busy_in) |-> !dc_prefetch_accept_out)
    else $error("prefetch request accepted while busy");
  a_load_hit_count: assert property ( // [R4]
    (quiet && s_r.code == EV_LOAD_HIT_PF && s_r.umask == UM_LOAD_HIT_PF &&
     load_hit_prefetch_in) |=> s_r.counter == $past(s_r.counter) + 1)
    else $error("load hitting a prefetch not counted");
  a_t1t2_miss_count: assert property ( // [R2]
    (quiet && s_r.code == EV_PF_MISS && s_r.umask == UM_PF_T1T2 && prefetch_miss_in &&
     (prefetch_hint_in == HINT_SECOND_A || prefetch_hint_in == HINT_SECOND_B))
    |=> s_r.counter == $past(s_r.counter) + 1)
    else $error("second-level prefetch miss not counted");
  a_miss_bad_umask: assert property ( // [R16]
    (quiet && s_r.code == EV_PF_MISS && s_r.umask != UM_PF_T0 && s_r.umask != UM_PF_T1T2)
    |=> s_r.counter == $past(s_r.counter))
    else $error("prefetch miss counted on a foreign umask");
  a_own_data_count: assert property ( // [R13] [R14]
    (quiet && s_r.code == EV_DATA_VALID && s_r.umask == UM_AGENT_THIS &&
     data_valid_strobe_in && own_data_drive_in) |=> s_r.counter == $past(s_r.counter) + 1)
    else $error("own data cycle not counted");
  a_full_line_pending: assert property ( // [R7]
    (issue_grant_out && issue_full_line_in && !line_done_in && s_r.pending != PEND_MAX)
    |=> s_r.pending == $past(s_r.pending) + 1)
    else $error("full-line read not made pending");
  a_read_drain: assert property ( // [R7]
    (line_done_in && !issue_grant_out && s_r.pending != '0)
    |=> s_r.pending == $past(s_r.pending) - 1)
    else $error("finished read still pending");

endmodule
`default_nettype wire

// ---- design/perf_event_pkg.sv ----
package perf_event_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  // ==========================================================
  // Control and status field layout
  localparam int CTRL_CODE_LSB = 0;
  localparam int CTRL_UMASK_LSB = 8;
  localparam int CTRL_EN_BIT = 16;
  localparam int STAT_STALL_BIT = 16;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_CODE = 8'h00;
  localparam logic [7:0] RST_UMASK = 8'h00;
  localparam logic RST_EN = 1'b0;

  // ==========================================================
  // Event codes and umasks
  localparam logic [7:0] EV_PF_MISS = 8'h4b;
  localparam logic [7:0] EV_LOAD_HIT_PF = 8'h4c;
  localparam logic [7:0] EV_DC_PF_REQ = 8'h4e;
  localparam logic [7:0] EV_READ_PENDING = 8'h60;
  localparam logic [7:0] EV_STALL = 8'h61;
  localparam logic [7:0] EV_DATA_VALID = 8'h62;
  localparam logic [7:0] UM_PF_T0 = 8'h01;
  localparam logic [7:0] UM_PF_T1T2 = 8'h02;
  localparam logic [7:0] UM_LOAD_HIT_PF = 8'h00;
  localparam logic [7:0] UM_DC_PF_REQ = 8'h10;
  localparam logic [7:0] UM_AGENT_THIS = 8'h40;
  localparam logic [7:0] UM_AGENT_ALL = 8'hc0;

  // ==========================================================
  // Prefetch hint encoding
  localparam logic [1:0] HINT_ALL_LEVELS = 2'h1;
  localparam logic [1:0] HINT_SECOND_A = 2'h2;
  localparam logic [1:0] HINT_SECOND_B = 2'h3;

  // ==========================================================
  // Stall assertion length in bus cycles
  localparam logic [1:0] STALL_CYCLES = 2'h2;

endpackage

// ---- tb/bus_agent_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module bus_agent_model (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic stall_cmd_in,
  input wire logic dv_cmd_in,
  input wire logic done_cmd_in,
  input wire logic our_stall_in,
  output logic bus_not_ready_out,
  output logic data_valid_out,
  output logic line_done_out
);
  // ==========================================================
  // Other bus agents
  logic [1:0] hold_r;
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      hold_r <= 2'h0;
      data_valid_out <= 1'b0;
      line_done_out <= 1'b0;
    end else begin
      if (hold_r != 2'h0) hold_r <= hold_r - 2'h1;
      else if (stall_cmd_in) hold_r <= 2'h2;
      data_valid_out <= dv_cmd_in & ~our_stall_in;
      line_done_out <= done_cmd_in;
    end
  end
  assign bus_not_ready_out = (hold_r != 2'h0);
endmodule
`default_nettype wire

// ---- tb/prefetch_and_bus_event_counting_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module prefetch_and_bus_event_counting_tb;
  import perf_event_pkg::*;
  logic core_clk_in = 1'b0, rstn_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic prefetch_miss_in = 1'b0, load_hit_prefetch_in = 1'b0, dc_prefetch_req_in = 1'b0;
  logic l2_busy_in = 1'b0, issue_req_in = 1'b0, issue_full_line_in = 1'b0;
  logic own_data_drive_in = 1'b0, stall_cmd = 1'b0, dv_cmd = 1'b0, done_cmd = 1'b0;
  logic prev = 1'b0;
  logic [1:0] prefetch_hint_in = 2'h0;
  logic [3:0] outstanding_level_in = 4'h0;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0, rdata_out, v0, v1;
  logic dc_prefetch_accept_out, issue_grant_out, bus_not_ready_out;
  logic bus_not_ready_in, data_valid_strobe_in, line_done_in;
  logic [15:0] ev [8] = '{{EV_PF_MISS, UM_PF_T0}, {EV_PF_MISS, UM_PF_T1T2},
    {EV_LOAD_HIT_PF, UM_LOAD_HIT_PF}, {EV_DC_PF_REQ, UM_DC_PF_REQ},
    {EV_DATA_VALID, UM_AGENT_THIS}, {EV_DATA_VALID, UM_AGENT_ALL},
    {EV_PF_MISS, 8'h03}, {EV_DC_PF_REQ, 8'h00}};
  int want [8] = '{2, 2, 3, 4, 2, 5, 0, 0};
  int err_total = 0, checked = 0, hi = 0, rises = 0, bad = 0, h0, r0;

  always #50 core_clk_in = ~core_clk_in;

  perf_event_counter DUT (.core_clk_in, .rstn_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .prefetch_miss_in, .prefetch_hint_in, .load_hit_prefetch_in,
    .dc_prefetch_req_in, .l2_busy_in, .dc_prefetch_accept_out, .issue_req_in,
    .issue_full_line_in, .line_done_in, .issue_grant_out, .outstanding_level_in,
    .bus_not_ready_in, .bus_not_ready_out, .data_valid_strobe_in, .own_data_drive_in);

  bus_agent_model agents (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
    .stall_cmd_in(stall_cmd), .dv_cmd_in(dv_cmd), .done_cmd_in(done_cmd),
    .our_stall_in(bus_not_ready_out), .bus_not_ready_out(bus_not_ready_in),
    .data_valid_out(data_valid_strobe_in), .line_done_out(line_done_in));

  // ==========================================================
  // Stall monitor
  always @(posedge core_clk_in) begin
    prev <= bus_not_ready_out;
    if (bus_not_ready_out) hi <= hi + 1;
    if (bus_not_ready_out && !prev) rises <= rises + 1;
    if (issue_grant_out && (bus_not_ready_out || bus_not_ready_in)) bad <= bad + 1;
  end

  // ==========================================================
  // Tasks
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge core_clk_in);
    wr_in <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] v);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge core_clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
    @(posedge core_clk_in);
  endtask
  task cfg(input logic [15:0] e);
    addr_in <= ADDR_COUNT;
    wdata_in <= 32'h0;
    wr_in <= 1'b1;
    @(posedge core_clk_in);
    wr(ADDR_CTRL, {15'h0, 1'b1, e[7:0], e[15:8]});
  endtask
  task end_of_test;
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial begin
    repeat (8) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    @(posedge core_clk_in);
    rd(8'h0c, v0);
    chk("unmapped", v0, 32'h0);
    for (int t = 0; t < 8; t++) begin
      cfg(ev[t]);
      for (int i = 0; i < 7; i++) begin
        prefetch_miss_in <= (i < 6);
        prefetch_hint_in <= i[1:0];
        load_hit_prefetch_in <= (i < 3);
        dc_prefetch_req_in <= (i < 4);
        l2_busy_in <= i[0];
        dv_cmd <= (i < 5);
        own_data_drive_in <= (i == 1 || i == 2);
        @(posedge core_clk_in);
        chk("accept", {31'h0, dc_prefetch_accept_out}, {31'h0, dc_prefetch_req_in & ~l2_busy_in});
      end
      wr(ADDR_CTRL, 32'h0);
      rd(ADDR_COUNT, v0);
      chk("count", v0, 32'(want[t]));
      $display("event test %0d done", t);
    end
    cfg({EV_READ_PENDING, UM_AGENT_THIS});
    issue_req_in <= 1'b1;
    issue_full_line_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    issue_full_line_in <= 1'b0;
    @(posedge core_clk_in);
    issue_req_in <= 1'b0;
    rd(ADDR_STATUS, v0);
    chk("pending", v0, 32'h2);
    rd(ADDR_COUNT, v0);
    rd(ADDR_COUNT, v1);
    chk("pend_sum", v1 - v0, 32'h4);
    done_cmd <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    done_cmd <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    rd(ADDR_STATUS, v0);
    chk("drained", v0, 32'h0);
    $display("pending test done");
    cfg({EV_STALL, UM_AGENT_THIS});
    h0 = hi;
    r0 = rises;
    issue_req_in <= 1'b1;
    outstanding_level_in <= 4'h5;
    repeat (4) @(posedge core_clk_in);
    chk("no_stall", 32'(rises - r0), 32'h0);
    outstanding_level_in <= 4'h6;
    stall_cmd <= 1'b1;
    repeat (10) @(posedge core_clk_in);
    outstanding_level_in <= 4'h0;
    stall_cmd <= 1'b0;
    issue_req_in <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    wr(ADDR_CTRL, 32'h0);
    rd(ADDR_COUNT, v0);
    chk("stalls", v0, 32'(rises - r0));
    chk("stall_len", 32'(hi - h0), 32'(2 * (rises - r0)));
    chk("started", {31'h0, rises > r0}, 32'h1);
    chk("starts", 32'(rises - r0), 32'h4);
    chk("grant", 32'(bad), 32'h0);
    $display("stall test done");
    end_of_test;
  end

  initial begin
    repeat (3000) @(posedge core_clk_in);
    err_total++;
    end_of_test;
  end
endmodule
`default_nettype wire
